// file: pfo_params.svh
`ifndef PFO_PARAMS_SVH
`define PFO_PARAMS_SVH
`define PFO_ADDR_OVD 4'h0
`define PFO_ADDR_SECMP 4'h1
`define PFO_ADDR_CON2 4'h2
`define PFO_ADDR_FLTA 4'h3
`define PFO_ADDR_FLTB 4'h4
`define PFO_ADDR_CTRL 4'h5
`define PFO_ADDR_STAT 4'h6
`define PFO_OVD_RST 16'hff00
`define PFO_CON2_UPD_OFF 0
`define PFO_CON2_OVR_SYNC 1
`define PFO_SEV_DIR 15
`define PFO_FLT_MODE 15
`endif

// file: pfo_pkg.sv
package pfo_pkg;
  typedef enum logic [1:0] {
    PFO_NORMAL = 2'b00,
    PFO_FAULT_A = 2'b01,
    PFO_FAULT_B = 2'b10
  } pfo_fstate_t;
  typedef struct packed {
    logic [3:0] en;
    logic [7:0] st;
    logic latched;
  } pfo_fcfg_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pfo_bus_t;
endpackage : pfo_pkg

// file: pfo_top.sv
`timescale 1ns/1ps
`include "pfo_params.svh"
// Summary of operation
// - Fault A states win over fault B states on a shared pair.
// - A clears with B asserted: fault B states at next boundary.
// - A clears with B idle: normal PWM at next boundary.
// - Latched A holds until flag cleared and input released.
// - Fault pin as output with port bit low counts as asserted.
// - Fault pin set to output ignores external drive.
// - Override register: select bits 15:8, manual values 7:0.
// - Select bit low means pin takes manual value.
// - Manual one drives active state, zero inactive.
// - Complementary pair never both active; high side wins.
// - Dead time does not apply to overridden pins; only pwm_in carries it.
// - Override sync bit defers override changes to sync point.
// - Sync point is counter zero or counter equal period.
// - Trigger on counter equal compare value.
// - Up/down mode: bit 15 picks up or down phase.
// - Trigger always produced; no enable bit.
// - Postscale bits 11:8 give ratio 1:1 to 1:16.
// - Postscaler cleared by compare write and by reset.
// - Update disable blocks duty and period transfers.
// - Optional tri-state of enabled pins while debugger halts.
// - Reset behaviour and polarity set by three config bits.
// - Active states are mapped through per-side (high-side, low-side) polarity.
// - Boundary: zero edge-aligned; zero or period center-aligned.
module pfo_top #(
  parameter int TW = 15
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic [TW-1:0] time_base_counter,
  input wire logic [TW-1:0] period_value,
  input wire logic count_down,
  input wire logic up_down_mode,
  input wire logic center_mode,
  input wire logic time_base_enable,
  input wire logic [7:0] pwm_in,
  input wire logic [7:0] pin_enable,
  input wire logic [3:0] pair_independent_select,
  input wire logic fault_input_a_pin,
  input wire logic fault_input_b_pin,
  input wire logic [1:0] pin_direction,
  input wire logic [1:0] port_output,
  input wire logic fault_a_irq_flag,
  input wire logic debug_halt,
  input wire logic high_side_polarity,
  input wire logic low_side_polarity,
  input wire logic pins_reset_driven,
  output logic [7:0] pwm_out,
  output logic [7:0] pwm_oe,
  output logic special_event_trigger,
  output logic update_allow
);
  pfo_pkg::pfo_bus_t bus;
  logic [15:0] ovd_q;
  logic [15:0] ovd_act_q;
  logic [15:0] secmp_q;
  logic [15:0] con2_q;
  pfo_pkg::pfo_fcfg_t fa_q;
  pfo_pkg::pfo_fcfg_t fb_q;
  logic halt_tri_q;
  logic [1:0] fa_s_q;
  logic [1:0] fb_s_q;
  logic [1:0] dh_s_q;
  logic fa_ext;
  logic fb_ext;
  logic fa_act;
  logic fb_act;
  logic fa_hold_q;
  logic boundary;
  logic sync_pt;
  logic sev_match;
  logic [3:0] post_q;
  logic cfg_seen_q;
  logic oe_en_q;
  pfo_pkg::pfo_fstate_t fst_q;
  logic [7:0] pol;
  logic [7:0] ovd_val;
  logic [7:0] fin;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // Even bits are high sides, odd bits low sides.
  assign pol = {4{low_side_polarity, high_side_polarity}};

  // Fault pins pass two flip-flops before use.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fa_s_q <= 2'b11;
      fb_s_q <= 2'b11;
      dh_s_q <= 2'b00;
    end else begin
      fa_s_q <= {fa_s_q[0], fault_input_a_pin};
      fb_s_q <= {fb_s_q[0], fault_input_b_pin};
      dh_s_q <= {dh_s_q[0], debug_halt};
    end
  end

  // Output direction hides the pin and uses the port bit instead.
  assign fa_ext = pin_direction[0] ? ~port_output[0] : ~fa_s_q[1];
  assign fb_ext = pin_direction[1] ? ~port_output[1] : ~fb_s_q[1];
  assign fa_act = fa_ext && (fa_q.en != 4'h0);
  assign fb_act = fb_ext && (fb_q.en != 4'h0);

  // A boundary is immediate when the time base is stopped.
  assign boundary = !time_base_enable || (time_base_counter == '0) ||
                    (center_mode && (time_base_counter == period_value));

  // Override sync points are zero and the period match in every counting mode.
  assign sync_pt = !time_base_enable || (time_base_counter == '0) ||
                   (time_base_counter == period_value);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        `PFO_ADDR_OVD: bus_rdata <= ovd_q;
        `PFO_ADDR_SECMP: bus_rdata <= secmp_q;
        `PFO_ADDR_CON2: bus_rdata <= con2_q;
        `PFO_ADDR_FLTA: bus_rdata <= {fa_q.latched, 3'h0, fa_q.en, fa_q.st};
        `PFO_ADDR_FLTB: bus_rdata <= {fb_q.latched, 3'h0, fb_q.en, fb_q.st};
        `PFO_ADDR_CTRL: bus_rdata <= {15'h0000, halt_tri_q};
        `PFO_ADDR_STAT: bus_rdata <= {12'h000, post_q[1:0], fst_q};
        default: bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovd_q <= `PFO_OVD_RST;
      secmp_q <= 16'h0000;
      con2_q <= 16'h0000;
      fa_q <= '0;
      fb_q <= '0;
      halt_tri_q <= 1'b0;
    end else if (bus.wr) begin
      case (bus.addr)
        `PFO_ADDR_OVD: ovd_q <= bus.wdata;
        `PFO_ADDR_SECMP: secmp_q <= bus.wdata;
        `PFO_ADDR_CON2: con2_q <= {4'h0, bus.wdata[11:8], 6'h00, bus.wdata[1:0]};
        `PFO_ADDR_FLTA: fa_q <= {bus.wdata[11:8], bus.wdata[7:0], bus.wdata[`PFO_FLT_MODE]};
        `PFO_ADDR_FLTB: fb_q <= {bus.wdata[11:8], bus.wdata[7:0], bus.wdata[`PFO_FLT_MODE]};
        `PFO_ADDR_CTRL: halt_tri_q <= bus.wdata[0];
        default: ;
      endcase
    end
  end

  // Override changes are copied at the sync point when sync is on.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovd_act_q <= `PFO_OVD_RST;
    end else if (!con2_q[`PFO_CON2_OVR_SYNC] || sync_pt) begin
      ovd_act_q <= ovd_q;
    end
  end

  // Latched fault A stays held until both the input and the flag clear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fa_hold_q <= 1'b0;
    end else if (fa_act) begin
      fa_hold_q <= fa_q.latched;
    end else if (!fault_a_irq_flag) begin
      fa_hold_q <= 1'b0;
    end
  end

  // Entry is immediate; exit or downgrade waits for a boundary.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fst_q <= pfo_pkg::PFO_NORMAL;
    end else begin
      case (fst_q)
        pfo_pkg::PFO_NORMAL: begin
          if (fa_act) fst_q <= pfo_pkg::PFO_FAULT_A;
          else if (fb_act) fst_q <= pfo_pkg::PFO_FAULT_B;
        end
        pfo_pkg::PFO_FAULT_A: begin
          if (!fa_act && !fa_hold_q && boundary) begin
            fst_q <= fb_act ? pfo_pkg::PFO_FAULT_B : pfo_pkg::PFO_NORMAL;
          end
        end
        pfo_pkg::PFO_FAULT_B: begin
          if (fa_act) fst_q <= pfo_pkg::PFO_FAULT_A;
          else if (!fb_act && boundary) fst_q <= pfo_pkg::PFO_NORMAL;
        end
        default: fst_q <= pfo_pkg::PFO_NORMAL;
      endcase
    end
  end

  // Dead time is upstream in pwm_in, so overridden pins carry none.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pair
      logic hi;
      logic lo;
      logic fh;
      logic fl;
      always_comb begin
        hi = ovd_act_q[8+2*gi] ? pwm_in[2*gi] : ovd_act_q[2*gi];
        lo = ovd_act_q[9+2*gi] ? pwm_in[2*gi+1] : ovd_act_q[2*gi+1];
        if (!pair_independent_select[gi] && !ovd_act_q[8+2*gi] && hi) lo = 1'b0;
        fh = hi;
        fl = lo;
        if ((fst_q == pfo_pkg::PFO_FAULT_A) && fa_q.en[gi]) begin
          fh = fa_q.st[2*gi];
          fl = fa_q.st[2*gi+1];
        end else if ((fst_q != pfo_pkg::PFO_NORMAL) && fb_q.en[gi]) begin
          fh = fb_q.st[2*gi];
          fl = fb_q.st[2*gi+1];
        end
        if (!pair_independent_select[gi] && fh) fl = 1'b0;
      end
      assign fin[2*gi] = fh;
      assign fin[2*gi+1] = fl;
    end
  endgenerate

  // A set polarity bit marks an active-low pin, so the level is inverted.
  assign ovd_val = fin ^ pol;

  // Configuration straps decide whether pins drive after reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_seen_q <= 1'b0;
      oe_en_q <= 1'b0;
    end else if (!cfg_seen_q) begin
      cfg_seen_q <= 1'b1;
      oe_en_q <= pins_reset_driven;
    end else if (bus.wr && bus.addr == `PFO_ADDR_OVD) begin
      oe_en_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= 8'h00;
      pwm_oe <= 8'h00;
    end else begin
      pwm_out <= ovd_val;
      pwm_oe <= (halt_tri_q && dh_s_q[1]) ? 8'h00 : (pin_enable & {8{oe_en_q}});
    end
  end

  assign sev_match = (time_base_counter == secmp_q[TW-1:0]) &&
                     (!up_down_mode || (count_down == secmp_q[`PFO_SEV_DIR]));

  // A stalled counter would match every cycle; fire once per arrival.
  logic match_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
    end else begin
      match_q <= sev_match;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      post_q <= 4'h0;
      special_event_trigger <= 1'b0;
    end else if (bus.wr && bus.addr == `PFO_ADDR_SECMP) begin
      post_q <= 4'h0;
      special_event_trigger <= 1'b0;
    end else if (sev_match && !match_q) begin
      if (post_q >= con2_q[11:8]) begin
        post_q <= 4'h0;
        special_event_trigger <= 1'b1;
      end else begin
        post_q <= post_q + 4'h1;
        special_event_trigger <= 1'b0;
      end
    end else begin
      special_event_trigger <= 1'b0;
    end
  end

  // The duty/period transfer logic outside obeys this level.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      update_allow <= 1'b1;
    end else begin
      update_allow <= !con2_q[`PFO_CON2_UPD_OFF];
    end
  end

  trig_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    special_event_trigger |=> !special_event_trigger)
    else $error("trigger longer than one cycle");
  comp_excl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pol == 8'h00 && !pair_independent_select[0]) |-> !(fin[0] && fin[1]))
    else $error("both pair pins active");
  sync_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (con2_q[`PFO_CON2_OVR_SYNC] && !sync_pt) |=> ovd_act_q == $past(ovd_act_q))
    else $error("override changed off sync point");
  fault_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fa_act |=> fst_q == pfo_pkg::PFO_FAULT_A)
    else $error("fault A not entered");
  latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q == pfo_pkg::PFO_FAULT_A && fa_hold_q) |=> fst_q == pfo_pkg::PFO_FAULT_A)
    else $error("latched fault left early");
  exit_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q != pfo_pkg::PFO_NORMAL && !boundary && $past(fst_q) == fst_q)
    |=> fst_q != pfo_pkg::PFO_NORMAL) else $error("fault exit off boundary");
  post_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == `PFO_ADDR_SECMP) |=> post_q == 4'h0)
    else $error("postscaler not cleared");
  update_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    con2_q[`PFO_CON2_UPD_OFF] |=> !update_allow)
    else $error("update not locked");
  halt_tri_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (halt_tri_q && dh_s_q[1]) |=> pwm_oe == 8'h00)
    else $error("pins not tri-stated");

  // The checks below tie fault states, pin levels, enables and trigger pulses back to the inputs and programmed values.
  override_reg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == `PFO_ADDR_OVD) |=> ovd_q == $past(bus.wdata))
    else $error("override register write lost");
  soft_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pin_direction[1] && !port_output[1] && fb_q.en != 4'h0)
    |=> fst_q != pfo_pkg::PFO_NORMAL) else $error("software fault not entered");
  pin_masked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pin_direction[1] && port_output[1] && !fa_act && fst_q == pfo_pkg::PFO_NORMAL)
    |=> fst_q == pfo_pkg::PFO_NORMAL) else $error("masked fault pin acted");
  fault_b_swap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q == pfo_pkg::PFO_FAULT_A && !fa_act && !fa_hold_q && boundary && fb_act)
    |=> fst_q == pfo_pkg::PFO_FAULT_B) else $error("fault B states not taken");
  fault_b_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q == pfo_pkg::PFO_FAULT_B && fb_act && !fa_act)
    |=> fst_q == pfo_pkg::PFO_FAULT_B) else $error("fault B left while asserted");
  fault_resume_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q != pfo_pkg::PFO_NORMAL && !fa_act && !fa_hold_q && !fb_act && boundary)
    |=> fst_q == pfo_pkg::PFO_NORMAL) else $error("normal output not resumed");
  ovd_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ovd_act_q[11] && fst_q == pfo_pkg::PFO_NORMAL && pair_independent_select[1])
    |=> pwm_out[3] == $past(ovd_act_q[3] ^ pol[3])) else $error("manual value not driven");
  fault_pol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q == pfo_pkg::PFO_FAULT_A && fa_q.en[0])
    |=> pwm_out[0] == $past(fa_q.st[0] ^ pol[0])) else $error("fault state level wrong");
  sync_point_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (con2_q[`PFO_CON2_OVR_SYNC] && sync_pt) |=> ovd_act_q == $past(ovd_q))
    else $error("override not applied at sync point");
  exit_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fst_q != pfo_pkg::PFO_NORMAL && time_base_enable && time_base_counter != '0 &&
    !(center_mode && time_base_counter == period_value))
    |=> fst_q != pfo_pkg::PFO_NORMAL) else $error("fault left between boundaries");
  trig_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    special_event_trigger |-> $past(sev_match))
    else $error("trigger without compare match");
  trig_dir_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (up_down_mode && (count_down != secmp_q[`PFO_SEV_DIR])) |=> !special_event_trigger)
    else $error("trigger in wrong count phase");
  trig_always_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sev_match && !match_q && con2_q[11:8] == 4'h0 &&
    !(bus.wr && bus.addr == `PFO_ADDR_SECMP)) |=> special_event_trigger)
    else $error("trigger missing at one to one");
  post_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sev_match && !match_q && post_q < con2_q[11:8] &&
    !(bus.wr && bus.addr == `PFO_ADDR_SECMP))
    |=> (!special_event_trigger && post_q == $past(post_q) + 4'h1))
    else $error("postscaler count wrong");
  reset_strap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_seen_q |=> oe_en_q == $past(pins_reset_driven))
    else $error("reset strap not applied");
  halt_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !dh_s_q[1] |=> pwm_oe == $past(pin_enable & {8{oe_en_q}}))
    else $error("pins not driven after halt");
endmodule : pfo_top

// file: pfo_plant_model.sv
`timescale 1ns/1ps
module pfo_plant_model (
  input wire logic mclk,
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_oe,
  input wire logic special_event_trigger,
  output logic [7:0] gate_level,
  output int conv_count
);
  // Gate inputs carry pull-downs, so a released pin reads low.
  assign gate_level = pwm_out & pwm_oe;
  initial conv_count = 0;
  // The converter takes the trigger as its start source.
  always @(posedge mclk) begin
    if (special_event_trigger === 1'b1) conv_count <= conv_count + 1;
  end
endmodule : pfo_plant_model

// file: tb.sv
`timescale 1ns/1ps
`include "pfo_params.svh"
module tb;
  localparam int PER = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic rd_d = 1'b0;
  logic fa = 1'b1, fb = 1'b1, flag = 1'b0, halt = 1'b0;
  logic down = 1'b0, up_dn = 1'b0, ctr = 1'b0;
  logic [3:0] indep = 4'he;
  logic [1:0] dir = 2'b00, manual_output_value = 2'b11;
  logic [7:0] pwm_r = 8'h00, pen = 8'hff;
  logic [7:0] pwm_out, pwm_oe, gate;
  logic [15:0] bus_rdata;
  logic [14:0] cnt, cv;
  logic sev, uall;
  int conv, c0, seed, n_fail = 0, total_checks = 0, cyc = 0;
  logic [15:0] rq[$];

  pfo_top dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .time_base_counter(cnt),
    .period_value(15'(PER)), .count_down(down), .up_down_mode(up_dn), .center_mode(ctr),
    .time_base_enable(1'b1), .pwm_in(pwm_r), .pin_enable(pen),
    .pair_independent_select(indep), .fault_input_a_pin(fa), .fault_input_b_pin(fb),
    .pin_direction(dir), .port_output(manual_output_value), .fault_a_irq_flag(flag), .debug_halt(halt),
    .high_side_polarity(1'b0), .low_side_polarity(1'b0), .pins_reset_driven(1'b1),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .special_event_trigger(sev), .update_allow(uall));

  pfo_plant_model plant (.mclk(mclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .special_event_trigger(sev), .gate_level(gate), .conv_count(conv));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt <= '0;
    else cnt <= (cnt == 15'(PER)) ? '0 : cnt + 15'h1;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic at(input logic [14:0] v);
    do @(posedge mclk); while (cnt !== v);
  endtask : at

  // Read data stand only in the cycle after the read strobe is taken.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_d <= bus_rd;
    if (rd_d) cmp(bus_rdata, rq.pop_front());
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    seed = 59308;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // Pair 0 is complementary, so its generator never shows both sides active.
    pwm_r <= 8'($random(seed)) & 8'hfd;
    pen <= 8'($random(seed));
    cv = 15'(($unsigned($random(seed)) % 12) + 2);
    @(posedge mclk);
    rd(`PFO_ADDR_OVD, `PFO_OVD_RST);
    wr(`PFO_ADDR_CON2, 16'h0203);
    rd(`PFO_ADDR_CON2, 16'h0203);
    cmp(16'(uall), 16'h0000);
    wr(`PFO_ADDR_CON2, 16'h0200);
    @(posedge mclk);
    cmp(16'(uall), 16'h0001);
    rd(4'hf, 16'h0000);
    $display("test done: registers");
    at(cv + 15'h3);
    wr(`PFO_ADDR_SECMP, {1'b0, cv});
    c0 = conv;
    repeat (2) at(cv + 15'h3);
    cmp(16'(conv - c0), 16'h0000);
    wr(`PFO_ADDR_SECMP, {1'b0, cv});
    repeat (2) at(cv + 15'h3);
    cmp(16'(conv - c0), 16'h0000);
    repeat (7) at(cv + 15'h3);
    cmp(16'(conv - c0), 16'h0003);
    wr(`PFO_ADDR_CON2, 16'h0000);
    up_dn <= 1'b1;
    wr(`PFO_ADDR_SECMP, {1'b1, cv});
    c0 = conv;
    repeat (2) at(cv + 15'h3);
    cmp(16'(conv - c0), 16'h0000);
    down <= 1'b1;
    repeat (2) at(cv + 15'h3);
    cmp(16'(conv - c0), 16'h0002);
    up_dn <= 1'b0;
    down <= 1'b0;
    $display("test done: trigger");
    wr(`PFO_ADDR_CON2, 16'h0202);
    at(15'h3);
    wr(`PFO_ADDR_OVD, 16'hf00f);
    repeat (3) @(posedge mclk);
    cmp(16'(pwm_out), 16'(pwm_r));
    at(15'h4);
    cmp(16'(pwm_out), 16'({pwm_r[7:4], 4'hd}));
    wr(`PFO_ADDR_CTRL, 16'h0001);
    halt <= 1'b1;
    repeat (6) @(posedge mclk);
    cmp(16'(pwm_oe), 16'h0000);
    cmp(16'(gate), 16'h0000);
    halt <= 1'b0;
    repeat (6) @(posedge mclk);
    cmp(16'(pwm_oe), 16'(pen));
    wr(`PFO_ADDR_CON2, 16'h0200);
    wr(`PFO_ADDR_OVD, `PFO_OVD_RST);
    $display("test done: override");
    wr(`PFO_ADDR_FLTA, 16'h8101);
    wr(`PFO_ADDR_FLTB, 16'h0102);
    flag <= 1'b1;
    fa <= 1'b0;
    dir <= 2'b10;
    manual_output_value <= 2'b01;
    repeat (6) @(posedge mclk);
    cmp(16'(pwm_out), 16'({pwm_r[7:2], 2'b01}));
    at(15'h2);
    fa <= 1'b1;
    repeat (25) @(posedge mclk);
    cmp(16'(pwm_out), 16'({pwm_r[7:2], 2'b01}));
    at(15'h2);
    flag <= 1'b0;
    repeat (4) @(posedge mclk);
    cmp(16'(pwm_out), 16'({pwm_r[7:2], 2'b01}));
    at(15'h4);
    cmp(16'(pwm_out), 16'({pwm_r[7:2], 2'b10}));
    fb <= 1'b0;
    manual_output_value <= 2'b11;
    ctr <= 1'b1;
    repeat (4) @(posedge mclk);
    cmp(16'(pwm_out), 16'({pwm_r[7:2], 2'b10}));
    // Center mode leaves at the period match, one edge ahead of the zero.
    at(15'h1);
    cmp(16'(pwm_out), 16'(pwm_r));
    ctr <= 1'b0;
    $display("test done: faults");
    wrap_up();
  end
endmodule : tb
